//--- design/rbtd_pkg.sv
// Overview of operation
// - Split one 128-bit block into two words
// - Lowest-address byte is most significant
// - Color word goes to RGB path unchanged
// - Base value is alpha word top byte
// - Multiplier is next four bits, 0 to 15
// - Next four bits select modifier table
// - Low 48 bits: sixteen 3-bit pixel selectors
// - Highest bit of each selector is MSB
// - Sixteen modifier rows held as fixed ROM
// - Selector n picks entry n from left
// - Alpha is base plus modifier times multiplier, saturated
// - Zero multiplier gives base value everywhere
// - sRGB variant: same alpha, color flagged sRGB
// - Alpha datapath may share single-channel hardware; here it is 8-bit only, nothing shared
package rbtd_pkg;

    // ------------------------------------------------------------
    // Block geometry
    // ------------------------------------------------------------
    localparam int BLK_BYTES  = 16;   // Bytes in one compressed block
    localparam int WORD_BYTES = 8;    // Bytes in one 64-bit word
    localparam int TEXELS     = 16;   // Texels in a 4x4 tile
    localparam int SEL_W      = 3;    // Width of one pixel selector

    // ------------------------------------------------------------
    // Alpha word field positions
    // ------------------------------------------------------------
    localparam int BASE_HI = 63;      // Base value top bit
    localparam int BASE_LO = 56;      // Base value low bit
    localparam int MULT_HI = 55;      // Multiplier top bit
    localparam int MULT_LO = 52;      // Multiplier low bit
    localparam int TSEL_HI = 51;      // Table selector top bit
    localparam int TSEL_LO = 48;      // Table selector low bit
    localparam int PIX_HI  = 47;      // Selector of pixel a, top bit

    // ------------------------------------------------------------
    // Saturation bounds and the low clip value
    // ------------------------------------------------------------
    localparam logic signed [10:0] ALPHA_MAX = 11'sd255;
    localparam logic signed [10:0] ALPHA_MIN = 11'sd0;
    localparam logic [7:0]         ZERO8     = 8'h00;

    // ------------------------------------------------------------
    // Signed modifier ROM: row = table selector, column = pixel value
    // ------------------------------------------------------------
    localparam logic signed [4:0] MOD_ROM [16][8] = '{
        '{-5'sd3, -5'sd6, -5'sd9,  -5'sd15, 5'sd2, 5'sd5, 5'sd8, 5'sd14},
        '{-5'sd3, -5'sd7, -5'sd10, -5'sd13, 5'sd2, 5'sd6, 5'sd9, 5'sd12},
        '{-5'sd2, -5'sd5, -5'sd8,  -5'sd13, 5'sd1, 5'sd4, 5'sd7, 5'sd12},
        '{-5'sd2, -5'sd4, -5'sd6,  -5'sd13, 5'sd1, 5'sd3, 5'sd5, 5'sd12},
        '{-5'sd3, -5'sd6, -5'sd8,  -5'sd12, 5'sd2, 5'sd5, 5'sd7, 5'sd11},
        '{-5'sd3, -5'sd7, -5'sd9,  -5'sd11, 5'sd2, 5'sd6, 5'sd8, 5'sd10},
        '{-5'sd4, -5'sd7, -5'sd8,  -5'sd11, 5'sd3, 5'sd6, 5'sd7, 5'sd10},
        '{-5'sd3, -5'sd5, -5'sd8,  -5'sd11, 5'sd2, 5'sd4, 5'sd7, 5'sd10},
        '{-5'sd2, -5'sd6, -5'sd8,  -5'sd10, 5'sd1, 5'sd5, 5'sd7, 5'sd9},
        '{-5'sd2, -5'sd5, -5'sd8,  -5'sd10, 5'sd1, 5'sd4, 5'sd7, 5'sd9},
        '{-5'sd2, -5'sd4, -5'sd8,  -5'sd10, 5'sd1, 5'sd3, 5'sd7, 5'sd9},
        '{-5'sd2, -5'sd5, -5'sd7,  -5'sd10, 5'sd1, 5'sd4, 5'sd6, 5'sd9},
        '{-5'sd3, -5'sd4, -5'sd7,  -5'sd10, 5'sd2, 5'sd3, 5'sd6, 5'sd9},
        '{-5'sd1, -5'sd2, -5'sd3,  -5'sd10, 5'sd0, 5'sd1, 5'sd2, 5'sd9},
        '{-5'sd4, -5'sd6, -5'sd8,  -5'sd9,  5'sd3, 5'sd5, 5'sd7, 5'sd8},
        '{-5'sd3, -5'sd5, -5'sd7,  -5'sd9,  5'sd2, 5'sd4, 5'sd6, 5'sd8}
    };

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // One block request: byte 0 (lowest address) sits leftmost
    typedef struct packed {
        logic [0:15][7:0]  blk;      // Compressed block bytes
        logic [15:0][23:0] rgb;      // RGB path results, texel 0 at [0]
        logic              srgb;     // Block is the sRGB-with-alpha format
    } rbtd_req_t;

    // One decoded texel
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic [7:0] a;
    } rbtd_texel_t;

endpackage

//--- design/rbtd_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module rbtd_decoder
    import rbtd_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Block input handshake
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire rbtd_req_t              in_req,
    // Color word hand-off to the RGB path
    output logic [63:0]                 color_word,
    // Texel output handshake
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output rbtd_texel_t [TEXELS-1:0]    texels,
    output logic                        out_srgb
);

    // ------------------------------------------------------------
    // Handshake and word split
    // ------------------------------------------------------------
    logic                     out_valid_r;    // Output slot occupied
    logic                     out_valid_nxt;
    logic                     accept;         // Block taken this cycle
    logic [63:0]              alpha_word;     // First eight bytes
    logic [63:0]              color_word_w;   // Following eight bytes
    logic [63:0]              color_word_r;
    rbtd_texel_t [TEXELS-1:0] texels_r;
    rbtd_texel_t [TEXELS-1:0] texels_nxt;
    logic                     srgb_r;

    // Slot frees when the consumer takes the held texels
    // Ready stays combinational so a draining slot refills at once
    assign in_ready = !out_valid_r || out_ready;
    assign accept   = in_valid && in_ready;

    // Packed byte order places the lowest address in the top byte
    assign alpha_word   = in_req.blk[0:WORD_BYTES-1];
    assign color_word_w = in_req.blk[WORD_BYTES:BLK_BYTES-1];

    // ------------------------------------------------------------
    // Alpha header fields
    // ------------------------------------------------------------
    logic [7:0] base_val;     // Unsigned base value
    logic [3:0] mult_val;     // Multiplier 0..15
    logic [3:0] tab_sel;      // Modifier row for the whole block

    assign base_val = alpha_word[BASE_HI:BASE_LO];
    assign mult_val = alpha_word[MULT_HI:MULT_LO];
    assign tab_sel  = alpha_word[TSEL_HI:TSEL_LO];

    // ------------------------------------------------------------
    // Per-pixel alpha, pixel a at texel 0
    // ------------------------------------------------------------
    // Eight-bit datapath only: a zero multiplier means zero here, which
    // differs from the 11-bit single-channel meaning; no sharing built
    logic [TEXELS-1:0][2:0]        pix_sel;
    logic [TEXELS-1:0][7:0]        alpha_sat;

    genvar gi;
    generate
        for (gi = 0; gi < TEXELS; gi = gi + 1) begin : g_pix
            logic signed [4:0]  mod_v;     // Chosen modifier
            logic signed [10:0] prod_v;    // Modifier times multiplier
            logic signed [10:0] sum_v;     // Base plus product

            // Pixel a takes the highest three bits, MSB highest
            assign pix_sel[gi] =
                alpha_word[PIX_HI - SEL_W*gi -: SEL_W];
            // Selector n reads entry n from the left of the row
            assign mod_v  = MOD_ROM[tab_sel][pix_sel[gi]];
            // Zero multiplier yields zero product, base passes through
            assign prod_v = 11'(mod_v) *
                            $signed({7'h00, mult_val});
            // Base widened by zero bits, so the sum stays signed
            assign sum_v  = $signed({3'h0, base_val}) + prod_v;
            // Saturate to 0..255
            assign alpha_sat[gi] = (sum_v > ALPHA_MAX) ? 8'hff :
                                   (sum_v < ALPHA_MIN) ? ZERO8 :
                                   sum_v[7:0];
            // RGB passes through untouched beside the alpha
            assign texels_nxt[gi] = '{r: in_req.rgb[gi][23:16],
                                      g: in_req.rgb[gi][15:8],
                                      b: in_req.rgb[gi][7:0],
                                      a: alpha_sat[gi]};
        end
    endgenerate

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    // Slot fills on accept, drains on consumer take
    assign out_valid_nxt = accept ? 1'b1 :
                           (out_ready ? 1'b0 : out_valid_r);

    // Valid flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_valid_r <= 1'b0;
        end else begin
            out_valid_r <= out_valid_nxt;
        end
    end

    // Result registers load only on accept, then hold
    always_ff @(posedge clk) begin
        if (!nrst) begin
            texels_r     <= '0;
            color_word_r <= '0;
            srgb_r       <= 1'b0;
        end else if (accept) begin
            texels_r     <= texels_nxt;
            color_word_r <= color_word_w;
            srgb_r       <= in_req.srgb;
        end
    end

    // Every output but ready comes straight from a register
    assign out_valid  = out_valid_r;
    assign texels     = texels_r;
    assign color_word = color_word_r;
    assign out_srgb   = srgb_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // Reference alpha, from bit positions written out by hand
    // ------------------------------------------------------------
    // Pixel a reads bits 47..45, pixel p reads bits 2..0
    logic signed [10:0] ref_a0;    // Unclipped alpha of pixel a
    logic signed [10:0] ref_p;     // Unclipped alpha of pixel p

    // Base byte plus row entry times multiplier, for pixel a
    assign ref_a0 = $signed({3'h0, in_req.blk[0]}) +
        11'(MOD_ROM[in_req.blk[1][3:0]][in_req.blk[2][7:5]]) *
        $signed({7'h00, in_req.blk[1][7:4]});
    // Same sum for pixel p, whose selector ends the last alpha byte
    assign ref_p  = $signed({3'h0, in_req.blk[0]}) +
        11'(MOD_ROM[in_req.blk[1][3:0]][in_req.blk[7][2:0]]) *
        $signed({7'h00, in_req.blk[1][7:4]});

    // ------------------------------------------------------------
    // Handshake assertions
    // ------------------------------------------------------------
    // Valid rises one clock after every accepted block
    a_accept_valid: assert property (accept |=> out_valid)
        else $error("texels not valid one clock after accept");
    // A stalled consumer keeps seeing the same texels
    a_hold_stall: assert property (
        out_valid && !out_ready |=> out_valid && $stable(texels))
        else $error("texels changed while stalled");
    // Color word and format flag hold beside the texels
    a_hold_side: assert property (
        out_valid && !out_ready |=> $stable(color_word) && $stable(out_srgb))
        else $error("color word or flag changed while stalled");
    // Slot empties once the consumer takes and nothing new comes
    a_slot_drain: assert property (
        out_valid && out_ready && !accept |=> !out_valid)
        else $error("valid stayed high after the take");

    // ------------------------------------------------------------
    // Datapath assertions
    // ------------------------------------------------------------
    // Color word is bytes 8..15, byte 8 on top
    a_color_split: assert property (
        accept |=> color_word == $past(in_req.blk[8:15]))
        else $error("color word not from last eight bytes");
    // RGB path results reach the texels untouched
    a_rgb_pass: assert property (
        accept |=> texels[5].r == $past(in_req.rgb[5][23:16]) &&
                   texels[15].b == $past(in_req.rgb[15][7:0]))
        else $error("rgb result altered");
    // Zero multiplier leaves pixels a and j (texels 0 and 9) at the base value
    a_zero_mult: assert property (
        accept && in_req.blk[1][7:4] == 4'h0
        |=> texels[0].a == $past(in_req.blk[0]) &&
            texels[9].a == $past(in_req.blk[0]))
        else $error("zero multiplier did not give base");
    // In-range alpha of pixel a matches the reference
    a_pixel_a: assert property (
        accept && ref_a0 >= 0 && ref_a0 <= 255
        |=> texels[0].a == $past(ref_a0[7:0]))
        else $error("pixel a alpha wrong");
    // In-range alpha of pixel p matches the reference
    a_pixel_p: assert property (
        accept && ref_p >= 0 && ref_p <= 255
        |=> texels[15].a == $past(ref_p[7:0]))
        else $error("pixel p alpha wrong");
    // Sums above the top clip to full scale
    a_clip_high: assert property (
        accept && ref_a0 > 255 |=> texels[0].a == 8'hff)
        else $error("alpha not saturated high");
    // Sums below zero clip to zero
    a_clip_low: assert property (
        accept && ref_a0 < 0 |=> texels[0].a == 8'h00)
        else $error("alpha not saturated low");
    // Worked example: base 103, row 13, entry 3, multiplier 2
    a_pixel_b_tab13: assert property (
        accept && in_req.blk[1] == 8'h2d &&
        in_req.blk[2][4:2] == 3'h3 && in_req.blk[0] == 8'h67
        |=> texels[1].a == 8'h53)
        else $error("table 13 entry 3 example wrong");
    // Format flag follows the accepted block
    a_srgb_flag: assert property (
        accept |=> out_srgb == $past(in_req.srgb))
        else $error("srgb flag not carried");

    // ------------------------------------------------------------
    // Main scenarios reached
    // ------------------------------------------------------------
    // Stall release, back-to-back accepts, clipping, format, zero
    c_stall: cover property (out_valid && !out_ready ##1 out_ready);
    c_back: cover property (accept ##1 accept);
    c_clip_low: cover property (accept && ref_a0 < 0);
    c_srgb: cover property (accept && in_req.srgb);
    c_zero_mult: cover property (accept && in_req.blk[1][7:4] == 4'h0);

endmodule
`default_nettype wire

//--- tb/rbtd_sampler_model.sv
`timescale 1ns/100ps
`default_nettype none
module rbtd_sampler_model
    import rbtd_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // Bench control
    input  wire logic                     stall,
    // Texel handshake from the decoder
    input  wire logic                     out_valid,
    input  wire rbtd_texel_t [TEXELS-1:0] texels,
    output logic                          out_ready,
    // What the sampler has taken
    output rbtd_texel_t [TEXELS-1:0]      seen,
    output var int                        taken
);
    // ------------------------------------------------------------
    // Sampler side of the texel handshake
    // ------------------------------------------------------------
    // Ready follows the stall request, which only moves off the edge
    assign out_ready = !stall;

    // Capture texels on handshake; channels are kept as unsigned bytes
    always @(posedge clk) begin
        if (!nrst) begin
            seen  <= '0;
            taken <= 0;
        end else if (out_valid && out_ready) begin
            seen  <= texels;
            taken <= taken + 1;
        end
    end
endmodule
`default_nettype wire

//--- tb/rbtd_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
module rbtd_decoder_test
    import rbtd_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and reference data
    // ------------------------------------------------------------
    logic                     clk, nrst, in_valid, in_ready, out_valid;
    logic                     out_ready, out_srgb, stall, exp_s;
    rbtd_req_t                in_req;
    logic [63:0]              color_word, exp_cw;
    rbtd_texel_t [TEXELS-1:0] texels, seen, exp_t;
    int                       failures = 0;
    int                       compares = 0;
    int                       taken;
    // Reference modifier rows, written out independently of the design
    int rom [16][8] = '{
        '{-3,-6,-9,-15,2,5,8,14}, '{-3,-7,-10,-13,2,6,9,12},
        '{-2,-5,-8,-13,1,4,7,12}, '{-2,-4,-6,-13,1,3,5,12},
        '{-3,-6,-8,-12,2,5,7,11}, '{-3,-7,-9,-11,2,6,8,10},
        '{-4,-7,-8,-11,3,6,7,10}, '{-3,-5,-8,-11,2,4,7,10},
        '{-2,-6,-8,-10,1,5,7,9},  '{-2,-5,-8,-10,1,4,7,9},
        '{-2,-4,-8,-10,1,3,7,9},  '{-2,-5,-7,-10,1,4,6,9},
        '{-3,-4,-7,-10,2,3,6,9},  '{-1,-2,-3,-10,0,1,2,9},
        '{-4,-6,-8,-9,3,5,7,8},   '{-3,-5,-7,-9,2,4,6,8}};

    rbtd_decoder rbtd_decoder_inst (.clk(clk), .nrst(nrst),
        .in_valid(in_valid), .in_ready(in_ready), .in_req(in_req),
        .color_word(color_word), .out_valid(out_valid),
        .out_ready(out_ready), .texels(texels), .out_srgb(out_srgb));
    rbtd_sampler_model rbtd_sampler_model_inst (.clk(clk), .nrst(nrst),
        .stall(stall), .out_valid(out_valid), .texels(texels),
        .out_ready(out_ready), .seen(seen), .taken(taken));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [511:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t ns: %s", $time, what);
        end
    endtask

    task automatic print_verdict;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Build a block and its expected texels, then offer it
    task automatic offer(input logic [7:0] base, input logic [3:0] mul,
                         tsel, input int s, input logic srgb);
        logic [63:0] aw;
        int          a;
        @(negedge clk);
        aw = {base, mul, tsel, 48'h0};
        for (int i = 0; i < TEXELS; i++) begin
            aw[47-3*i -: 3] = 3'((i + s) % 8);
            a = int'(base) + rom[tsel][(i + s) % 8] * int'(mul);
            exp_t[i].a = (a > 255) ? 8'hff : (a < 0) ? 8'h00 : 8'(a);
            {exp_t[i].r, exp_t[i].g, exp_t[i].b} = {8'(i), base, 8'(s)};
            in_req.rgb[i] = {8'(i), base, 8'(s)};
        end
        exp_cw = ~aw ^ 64'h0123456789abcdef;
        exp_s = srgb;
        in_req.blk = {aw, exp_cw};
        in_req.srgb = srgb;
        in_valid = 1'b1;
    endtask

    // Hold the offer until ready is seen, then release after the edge
    task automatic take;
        int n;
        n = 0;
        #1;
        while (in_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            #1;
            n++;
        end
        chk(512'(in_ready), 512'(1'b1), "block never taken");
        @(negedge clk);
        in_valid = 1'b0;
    endtask

    task automatic check_out;
        chk(512'(out_valid), 512'(1'b1), "valid missing");
        chk(texels, exp_t, "texel values");
        chk(512'(color_word), 512'(exp_cw), "color word");
        chk(512'(out_srgb), 512'(exp_s), "srgb flag");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every table row and entry, multipliers 0 to 15, both formats
    task automatic t_tables;
        for (int t = 0; t < 16; t++) begin
            // Row 0 carries a zero multiplier, which no source sends
            offer(8'h80, 4'(t), 4'(t), t % 8, t[0]);
            take();
            check_out();
        end
    endtask

    // Saturation at both ends, then valid drops with no new block
    task automatic t_clamp;
        offer(8'hfa, 4'hf, 4'h0, 7, 1'b0);
        take();
        check_out();
        offer(8'h05, 4'hf, 4'h0, 2, 1'b1);
        take();
        check_out();
        @(negedge clk);
        chk(512'(out_valid), 512'(1'b0), "valid stuck");
    endtask

    // Worked example: base 103, row 13, multiplier 2, pixel b index 3
    task automatic t_example;
        offer(8'h67, 4'h2, 4'hd, 2, 1'b0);
        take();
        check_out();
        chk(512'(texels[1].a), 512'(8'h53), "worked example");
    endtask

    // Sampler stalls: next block refused, output held, then both move
    task automatic t_stall;
        rbtd_texel_t [TEXELS-1:0] held;
        int                       n0;
        offer(8'h40, 4'h3, 4'h7, 5, 1'b0);
        stall = 1'b1;
        take();
        check_out();
        held = exp_t;
        n0 = taken;
        offer(8'hc0, 4'h9, 4'h2, 3, 1'b1);
        repeat (3) begin
            #1;
            chk(512'(in_ready), 512'(1'b0), "ready in stall");
            chk(texels, held, "texels not held");
            @(negedge clk);
        end
        stall = 1'b0;
        take();
        check_out();
        chk(seen, held, "sampler data");
        chk(512'(taken - n0), 512'(1), "handshake count");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        in_valid = 1'b0;
        in_req = '0;
        stall = 1'b0;
        repeat (20) @(negedge clk);
        chk(512'({out_valid, out_srgb, color_word}), '0,
            "reset state");
        chk(texels, '0, "reset texels");
        nrst = 1'b1;
        t_tables();
        t_clamp();
        t_example();
        t_stall();
        print_verdict();
    end

    // The tests need about 70 cycles; 5000 cycles means a hang
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
